// >>> core/tsrb_top.sv
// temperature sensor register bank with alert control and bus time-out
`timescale 1ns/1ns
`include "tsrb_defs.svh"
// Summary of operation
// - alert output starts disabled after power-up.
// - limits are two's complement with quarter-degree least bit.
// - trip bits 15..13 compare temperature to limits, ignoring alert settings.
// - temperature in bits 12..0, sign at 12, sixteenth-degree least bit.
// - reserved upper capability and configuration bits ignore writes, read zero.
// - resolution field 00/01/10/11 means half/quarter/eighth/sixteenth degree.
// - shutdown-behaviour zero: shutdown freezes alert status and output.
// - during shutdown clear-event may clear but never set alert status.
// - stalled bus released after 25 to 35 ms.
// - hysteresis field selects 0, 1.5, 3 or 6 degrees.
// - shutdown stops conversion and holds temperature; otherwise readings update.
// - shutdown cannot be set while a lock is set; clearing always allowed.
// - critical lock blocks critical limit writes; cleared only by reset.
// - alarm lock blocks high and low limit writes; cleared only by reset.
// - clear-event clears latched event in interrupt mode; self-clearing, reads zero.
// - clear-event cannot de-assert alert while above critical limit.
// - alert status is polarity-independent copy of output, follows enable.
// - disabled alert pin inactive: released if active low, grounded if high.
// - critical-only limits events to critical; not settable under alarm lock.
// - polarity zero active low, one active high.
// - mode zero comparator, one interrupt.
// - hysteresis, enable, polarity, mode frozen while any lock set.
// - bit15 at/above critical, bit14 above high, bit13 below low.
// - interrupt mode asserts on each alarm window crossing until cleared.
// - comparator mode asserts while temperature outside alarm window.
// - two lowest bits of limit registers read zero.
module tsrb_top
  import tsrb_pkg::*;
#(
  parameter int unsigned TOUT_CYCLES = `TSRB_TOUT_CYC
) (
  input  wire logic         clk,
  input  wire logic         reset,
  input  wire logic         ce,
  input  wire tsrb_req_t    reg_req,
  output logic [15:0]       reg_rdata,
  input  wire tsrb_sample_t sample,
  output logic              conv_enable,
  input  wire logic         bus_stalled,
  output logic              bus_release,
  output logic              alert_out,
  output logic              alert_oe
);
  tsrb_cfg_t   cfg_q, cfg_d;
  logic [10:0] hi_q, hi_d, lo_q, lo_d, cr_q, cr_d;
  logic [12:0] temp_q, temp_d;
  logic        above_q, above_d, below_q, below_d, crit_q, crit_d;
  logic        ev_q, ev_d, pend_q, pend_d;
  logic        wr_cfg, clr_wr, locked, cond, crossing, do_clr;
  logic        crit_raw, high_raw, low_raw, status_w;
  logic [2:0]  trip_w;
  logic signed [13:0] t, hv, hi_s, lo_s, cr_s;
  logic [15:0] rdata_q, rdata_d;
  logic        conv_q, conv_d, aoe_q, aoe_d;
  logic [31:0] cnt_q, cnt_d;
  logic        rel_q, rel_d;
  logic        aout_q, aout_d;
  logic [31:0] srun_q, srun_d;

  // limit stored as bits 12..2, widened to sixteenths
  function automatic logic signed [13:0] lim_s(input logic [10:0] v);
    lim_s = $signed({v[10], v, 2'b00});
  endfunction

  assign wr_cfg   = ce & reg_req.wr & (reg_req.addr == `TSRB_A_CFG);
  assign clr_wr   = wr_cfg & reg_req.wdata[`TSRB_B_CLR];
  assign locked   = cfg_q.crit_lock | cfg_q.alarm_lock;
  assign status_w = ev_q & cfg_q.oe;
  assign trip_w   = {crit_raw, high_raw, low_raw};

  // core state: configuration, limits, temperature, event
  always_comb begin
    cfg_d    = cfg_q;
    hi_d     = hi_q;
    lo_d     = lo_q;
    cr_d     = cr_q;
    temp_d   = temp_q;
    t        = $signed({temp_q[12], temp_q});
    hi_s     = lim_s(hi_q);
    lo_s     = lim_s(lo_q);
    cr_s     = lim_s(cr_q);
    case (cfg_q.hysteresis_select)
      2'b00:   hv = `TSRB_HYSTERESIS_SELECT_0;
      2'b01:   hv = `TSRB_HYSTERESIS_SELECT_1;
      2'b10:   hv = `TSRB_HYSTERESIS_SELECT_2;
      default: hv = `TSRB_HYSTERESIS_SELECT_3;
    endcase
    crit_raw = t >= cr_s;
    high_raw = t > hi_s;
    low_raw  = t < lo_s;
    // window states with hysteresis, frozen in shutdown
    above_d  = above_q;
    below_d  = below_q;
    crit_d   = crit_q;
    if (!cfg_q.sensor_shutdown) begin
      above_d = above_q ? (t > hi_s - hv) : high_raw;
      below_d = below_q ? (t < lo_s + hv) : low_raw;
      crit_d  = crit_q ? (t >= cr_s - hv) : crit_raw;
    end
    cond     = cfg_q.crit_only ? crit_d : (above_d | below_d | crit_d);
    crossing = ~cfg_q.crit_only & ((above_d != above_q) | (below_d != below_q));
    do_clr   = (clr_wr | pend_q) & ~crit_d;
    pend_d   = pend_q;
    if (cfg_q.sensor_shutdown) begin
      ev_d = ev_q & ~(clr_wr & ~crit_q);
    end else if (!cfg_q.mode) begin
      ev_d   = cond;
      pend_d = 1'b0;
    end else begin
      // new crossing wins over a clear in the same cycle
      ev_d   = crossing | crit_d | (ev_q & ~do_clr);
      pend_d = (pend_q | clr_wr) & crit_d;
    end
    if (wr_cfg) begin
      // upper bits 15..11 are never stored
      if (!locked) begin
        cfg_d.hysteresis_select = reg_req.wdata[`TSRB_B_HYSTERESIS_SELECT +: 2];
        cfg_d.oe   = reg_req.wdata[`TSRB_B_OE];
        cfg_d.pol  = reg_req.wdata[`TSRB_B_POL];
        cfg_d.mode = reg_req.wdata[`TSRB_B_MODE];
      end
      if (!reg_req.wdata[`TSRB_B_SENSOR_SHUTDOWN]) begin
        cfg_d.sensor_shutdown = 1'b0;
      end else if (!locked) begin
        cfg_d.sensor_shutdown = 1'b1;
      end
      cfg_d.crit_lock  = cfg_q.crit_lock | reg_req.wdata[`TSRB_B_CLOCK];
      cfg_d.alarm_lock = cfg_q.alarm_lock | reg_req.wdata[`TSRB_B_ALOCK];
      if (!reg_req.wdata[`TSRB_B_CONLY]) begin
        cfg_d.crit_only = 1'b0;
      end else if (!cfg_q.alarm_lock) begin
        cfg_d.crit_only = 1'b1;
      end
    end
    if (ce && reg_req.wr) begin
      case (reg_req.addr)
        `TSRB_A_HIGH: if (!cfg_q.alarm_lock) hi_d = reg_req.wdata[12:2];
        `TSRB_A_LOW:  if (!cfg_q.alarm_lock) lo_d = reg_req.wdata[12:2];
        `TSRB_A_CRIT: if (!cfg_q.crit_lock) cr_d = reg_req.wdata[12:2];
        default:      ;
      endcase
    end
    if (sample.valid && !cfg_q.sensor_shutdown) begin
      temp_d = sample.temp;
    end
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      cfg_q   <= '0;
      hi_q    <= `TSRB_LIM_RESET;
      lo_q    <= `TSRB_LIM_RESET;
      cr_q    <= `TSRB_LIM_RESET;
      temp_q  <= `TSRB_TEMP_RESET;
      above_q <= 1'b0;
      below_q <= 1'b0;
      crit_q  <= 1'b0;
      ev_q    <= 1'b0;
      pend_q  <= 1'b0;
    end else if (ce) begin
      cfg_q   <= cfg_d;
      hi_q    <= hi_d;
      lo_q    <= lo_d;
      cr_q    <= cr_d;
      temp_q  <= temp_d;
      above_q <= above_d;
      below_q <= below_d;
      crit_q  <= crit_d;
      ev_q    <= ev_d;
      pend_q  <= pend_d;
    end
  end

  // read data and pin outputs
  always_comb begin
    rdata_d = rdata_q;
    if (reg_req.rd) begin
      case (reg_req.addr)
        `TSRB_A_CAP:   rdata_d = `TSRB_CAP_RESET;
        `TSRB_A_CFG:   rdata_d = {5'h00, cfg_q.hysteresis_select, cfg_q.sensor_shutdown, cfg_q.crit_lock,
                                  cfg_q.alarm_lock, 1'b0, status_w, cfg_q.oe,
                                  cfg_q.crit_only, cfg_q.pol, cfg_q.mode};
        `TSRB_A_HIGH:  rdata_d = {3'h0, hi_q, 2'h0};
        `TSRB_A_LOW:   rdata_d = {3'h0, lo_q, 2'h0};
        `TSRB_A_CRIT:  rdata_d = {3'h0, cr_q, 2'h0};
        `TSRB_A_TEMP:  rdata_d = {trip_w, temp_q};
        `TSRB_A_MAKER: rdata_d = `TSRB_MAKER_ID;
        default:       rdata_d = `TSRB_PART_ID;
      endcase
    end
    conv_d = ~cfg_d.sensor_shutdown;
    // pin pulled low when asserted active low or idle active high
    aoe_d  = (ev_d & cfg_d.oe) ^ cfg_d.pol;
    // open drain: only the enable ever moves
    aout_d = 1'b0;
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      rdata_q <= 16'h0000;
      conv_q  <= 1'b1;
      aoe_q   <= 1'b0;
      aout_q  <= 1'b0;
    end else if (ce) begin
      rdata_q <= rdata_d;
      conv_q  <= conv_d;
      aoe_q   <= aoe_d;
      aout_q  <= aout_d;
    end
  end

  // bus time-out counter
  always_comb begin
    cnt_d = 32'h0000_0000;
    rel_d = 1'b0;
    if (bus_stalled) begin
      if (cnt_q == TOUT_CYCLES - 1) begin
        rel_d = 1'b1;
      end else begin
        cnt_d = cnt_q + 32'h0000_0001;
      end
    end
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      cnt_q <= 32'h0000_0000;
      rel_q <= 1'b0;
    end else if (ce) begin
      cnt_q <= cnt_d;
      rel_q <= rel_d;
    end
  end

  // stalled cycles counted apart from the time-out counter, restarted by a release
  always_comb begin
    srun_d = 32'h0000_0000;
    if (bus_stalled) begin
      srun_d = bus_release ? 32'h0000_0001 : srun_q + 32'h0000_0001;
    end
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      srun_q <= 32'h0000_0000;
    end else if (ce) begin
      srun_q <= srun_d;
    end
  end

  assign reg_rdata   = rdata_q;
  assign conv_enable = conv_q;
  assign bus_release = rel_q;
  assign alert_out   = aout_q;
  assign alert_oe    = aoe_q;

  AST_DISABLED_IDLE: assert property (@(posedge clk) disable iff (reset)
    !cfg_q.oe |-> alert_oe == cfg_q.pol)
    else $error("disabled alert pin not idle");
  AST_TRIP_READ: assert property (@(posedge clk) disable iff (reset)
    ce && reg_req.rd && reg_req.addr == `TSRB_A_TEMP |=> reg_rdata[15:13] == $past(trip_w))
    else $error("trip bits wrong on read");
  AST_CRIT_LOCKED: assert property (@(posedge clk) disable iff (reset)
    cfg_q.crit_lock |=> cfg_q.crit_lock && $stable(cr_q))
    else $error("critical limit changed under lock");
  AST_ALARM_LOCKED: assert property (@(posedge clk) disable iff (reset)
    cfg_q.alarm_lock |=> cfg_q.alarm_lock && $stable(hi_q) && $stable(lo_q))
    else $error("alarm limits changed under lock");
  AST_SENSOR_SHUTDOWN_REFUSED: assert property (@(posedge clk) disable iff (reset)
    locked && !cfg_q.sensor_shutdown |=> !cfg_q.sensor_shutdown)
    else $error("shutdown set while locked");
  AST_TEMP_HELD: assert property (@(posedge clk) disable iff (reset)
    cfg_q.sensor_shutdown |=> $stable(temp_q))
    else $error("temperature moved in shutdown");
  AST_CMP_FOLLOW: assert property (@(posedge clk) disable iff (reset)
    ce && !cfg_q.mode && !cfg_q.sensor_shutdown |=> ev_q == $past(cond))
    else $error("comparator output wrong");
  AST_CRIT_STUCK: assert property (@(posedge clk) disable iff (reset)
    ce && cfg_q.mode && !cfg_q.sensor_shutdown && crit_d |=> ev_q)
    else $error("alert cleared above critical");
  AST_CFG_FROZEN: assert property (@(posedge clk) disable iff (reset)
    locked |=> $stable(cfg_q.hysteresis_select) && $stable(cfg_q.oe) && $stable(cfg_q.pol) && $stable(cfg_q.mode))
    else $error("locked field changed");
  AST_STATUS_READ: assert property (@(posedge clk) disable iff (reset)
    ce && reg_req.rd && reg_req.addr == `TSRB_A_CFG |=> reg_rdata[4] == $past(status_w) && !reg_rdata[5])
    else $error("status bit wrong on read");
  AST_TOUT_BOUND: assert property (@(posedge clk) disable iff (reset)
    bus_release |-> $past(bus_stalled) && cnt_q == 32'h0000_0000)
    else $error("release without stall");

  AST_STATUS_COPY: assert property (@(posedge clk) disable iff (reset)
    status_w == (alert_oe ^ cfg_q.pol))
    else $error("status bit not a copy of the pin");
  AST_OE_OFF_STATUS: assert property (@(posedge clk) disable iff (reset)
    !cfg_q.oe
    |-> !status_w)
    else $error("status set while output disabled");
  AST_POL_ACTIVE: assert property (@(posedge clk) disable iff (reset)
    cfg_q.oe && status_w
    |-> alert_oe == !cfg_q.pol)
    else $error("asserted pin level wrong for polarity");
  AST_CAP_FIELDS: assert property (@(posedge clk) disable iff (reset)
    ce && reg_req.rd && reg_req.addr == `TSRB_A_CAP
    |=> reg_rdata[15:8] == 8'h00 && reg_rdata[4:3] == 2'b11)
    else $error("capability word wrong");
  AST_CFG_UPPER: assert property (@(posedge clk) disable iff (reset)
    ce && reg_req.rd && reg_req.addr == `TSRB_A_CFG
    |=> reg_rdata[15:11] == 5'h00)
    else $error("reserved configuration bits not zero");
  AST_LIMIT_FORMAT: assert property (@(posedge clk) disable iff (reset)
    ce && reg_req.rd && (reg_req.addr == `TSRB_A_HIGH || reg_req.addr == `TSRB_A_LOW || reg_req.addr == `TSRB_A_CRIT)
    |=> reg_rdata[1:0] == 2'b00 && reg_rdata[15:13] == 3'h0)
    else $error("limit read format wrong");
  AST_TEMP_READ: assert property (@(posedge clk) disable iff (reset)
    ce && reg_req.rd && reg_req.addr == `TSRB_A_TEMP
    |=> reg_rdata[12:0] == $past(temp_q))
    else $error("temperature field wrong on read");
  AST_LIMIT_WRITE: assert property (@(posedge clk) disable iff (reset)
    ce && reg_req.wr && reg_req.addr == `TSRB_A_HIGH && !cfg_q.alarm_lock
    |=> hi_q == $past(reg_req.wdata[12:2]))
    else $error("high limit write lost");
  AST_CRIT_WRITE: assert property (@(posedge clk) disable iff (reset)
    ce && reg_req.wr && reg_req.addr == `TSRB_A_CRIT && !cfg_q.crit_lock
    |=> cr_q == $past(reg_req.wdata[12:2]))
    else $error("critical limit write lost");
  AST_INT_LATCH: assert property (@(posedge clk) disable iff (reset)
    ce && cfg_q.mode && !cfg_q.sensor_shutdown && ev_q && !clr_wr && !pend_q
    |=> ev_q)
    else $error("latched event dropped without clear");
  AST_INT_CROSS: assert property (@(posedge clk) disable iff (reset)
    ce && cfg_q.mode && !cfg_q.sensor_shutdown && crossing
    |=> ev_q)
    else $error("window crossing raised no event");
  AST_INT_CLEAR: assert property (@(posedge clk) disable iff (reset)
    ce && cfg_q.mode && !cfg_q.sensor_shutdown && clr_wr && !crossing && !crit_d
    |=> !ev_q)
    else $error("clear did not remove event");
  AST_CMP_CLEAR: assert property (@(posedge clk) disable iff (reset)
    ce && !cfg_q.mode && !cfg_q.sensor_shutdown && clr_wr && cond
    |=> ev_q)
    else $error("clear acted in comparator mode");
  AST_CONLY_REFUSED: assert property (@(posedge clk) disable iff (reset)
    cfg_q.alarm_lock && !cfg_q.crit_only
    |=> !cfg_q.crit_only)
    else $error("critical-only set under alarm lock");
  AST_CONLY_QUIET: assert property (@(posedge clk) disable iff (reset)
    ce && cfg_q.mode && !cfg_q.sensor_shutdown && cfg_q.crit_only && !crit_d && !ev_q
    |=> !ev_q)
    else $error("alarm event raised in critical-only mode");
  AST_SENSOR_SHUTDOWN_FREEZE: assert property (@(posedge clk) disable iff (reset)
    cfg_q.sensor_shutdown && !clr_wr
    |=> $stable(ev_q) && $stable(above_q) && $stable(below_q))
    else $error("alert state moved in shutdown");
  AST_SENSOR_SHUTDOWN_NO_SET: assert property (@(posedge clk) disable iff (reset)
    cfg_q.sensor_shutdown && !ev_q
    |=> !ev_q)
    else $error("event set in shutdown");
  AST_CONV_STOP: assert property (@(posedge clk) disable iff (reset)
    conv_enable != cfg_q.sensor_shutdown)
    else $error("converter enable disagrees with shutdown");
  AST_HYSTERESIS_SELECT_NONE: assert property (@(posedge clk) disable iff (reset)
    ce && !cfg_q.sensor_shutdown && cfg_q.hysteresis_select == 2'b00
    |=> above_q == $past(high_raw) && below_q == $past(low_raw) && crit_q == $past(crit_raw))
    else $error("window state lags with hysteresis off");
  AST_RELEASE_PULSE: assert property (@(posedge clk) disable iff (reset)
    ce && bus_release
    |=> !bus_release)
    else $error("release longer than one cycle");
  AST_TOUT_SPAN: assert property (@(posedge clk) disable iff (reset)
    bus_release
    |-> srun_q == TOUT_CYCLES)
    else $error("release after wrong stall length");
  AST_TOUT_NO_EARLY: assert property (@(posedge clk) disable iff (reset)
    ce && bus_stalled && srun_q < TOUT_CYCLES - 1
    |=> !bus_release)
    else $error("release before time-out");
endmodule

// >>> inc/tsrb_defs.svh
// register offsets, field positions, reset values and timing counts
`ifndef TSRB_DEFS_SVH
`define TSRB_DEFS_SVH
`define TSRB_A_CAP      3'h0
`define TSRB_A_CFG      3'h1
`define TSRB_A_HIGH     3'h2
`define TSRB_A_LOW      3'h3
`define TSRB_A_CRIT     3'h4
`define TSRB_A_TEMP     3'h5
`define TSRB_A_MAKER    3'h6
`define TSRB_A_PART     3'h7
`define TSRB_CAP_RESET  16'h007f
`define TSRB_CFG_RESET  16'h0000
`define TSRB_LIM_RESET  11'h000
`define TSRB_TEMP_RESET 13'h0000
// arbitrary identification values
`define TSRB_MAKER_ID   16'h0001
`define TSRB_PART_ID    16'h0100
`define TSRB_B_MODE     0
`define TSRB_B_POL      1
`define TSRB_B_CONLY    2
`define TSRB_B_OE       3
`define TSRB_B_STS      4
`define TSRB_B_CLR      5
`define TSRB_B_ALOCK    6
`define TSRB_B_CLOCK    7
`define TSRB_B_SENSOR_SHUTDOWN     8
`define TSRB_B_HYSTERESIS_SELECT     9
// hysteresis in 1/16 degree steps: 1.5, 3 and 6 degrees
`define TSRB_HYSTERESIS_SELECT_0     14'h0000
`define TSRB_HYSTERESIS_SELECT_1     14'h0018
`define TSRB_HYSTERESIS_SELECT_2     14'h0030
`define TSRB_HYSTERESIS_SELECT_3     14'h0060
`define TSRB_CLK_MHZ    100
`define TSRB_TOUT_MS    25
`define TSRB_TOUT_CYC   (`TSRB_TOUT_MS * 1000 * `TSRB_CLK_MHZ)
`endif

// >>> inc/tsrb_pkg.sv
// types shared by the temperature sensor register bank
package tsrb_pkg;
  typedef struct packed {
    logic [1:0] hysteresis_select;
    logic       sensor_shutdown;
    logic       crit_lock;
    logic       alarm_lock;
    logic       oe;
    logic       crit_only;
    logic       pol;
    logic       mode;
  } tsrb_cfg_t;
  typedef struct packed {
    logic        wr;
    logic        rd;
    logic [2:0]  addr;
    logic [15:0] wdata;
  } tsrb_req_t;
  typedef struct packed {
    logic valid;
    logic [12:0] temp;
  } tsrb_sample_t;
endpackage

// >>> tb/test_temp_sensor_register_bank.sv
// self-checking bench for the temperature sensor register bank
`timescale 1ns/1ns
`include "tsrb_defs.svh"
`define CHK(a, e) begin comparisons++; if ((a) !== (e)) begin n_mismatch++; \
  $display("FAIL %0t got %h want %h", $time, a, e); end end
module test_temp_sensor_register_bank
  import tsrb_pkg::*;
;
  logic         clk, reset, stall, rel, aout, aoe, cen;
  logic [15:0]  rdata, lf;
  logic [12:0]  temp, t;
  logic [2:0]   x;
  tsrb_req_t    req;
  tsrb_sample_t smp;
  int           n_mismatch, comparisons, n;

  tsrb_top #(.TOUT_CYCLES(20)) dut (.clk(clk), .reset(reset), .ce(1'b1), .reg_req(req),
    .reg_rdata(rdata), .sample(smp), .conv_enable(cen), .bus_stalled(stall),
    .bus_release(rel), .alert_out(aout), .alert_oe(aoe));
  tsrb_conv_model conv (.clk(clk), .reset(reset), .conv_enable(cen), .temp_in(temp), .sample(smp));

  function automatic logic [15:0] lfsr(input logic [15:0] v);
    return {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
  endfunction
  // raw trip flags against limits 0x07d0, 0x0320, 0x0190
  function automatic logic [2:0] trips(input logic [12:0] v);
    return {$signed(v) >= $signed(13'h07d0), $signed(v) > $signed(13'h0320), $signed(v) < $signed(13'h0190)};
  endfunction

  task automatic acc(input logic w, input logic [2:0] a, input logic [15:0] d);
    @(posedge clk);
    req <= '{w, ~w, a, d};
    @(posedge clk);
    req <= '0;
  endtask
  task automatic rd(input logic [2:0] a, input logic [15:0] e);
    acc(1'b0, a, 16'h0);
    #1 `CHK(rdata, e)
  endtask
  task automatic wr(input logic [2:0] a, input logic [15:0] d);
    acc(1'b1, a, d);
    repeat (2) @(posedge clk);
    #1;
  endtask
  task automatic settemp(input logic [12:0] v);
    @(posedge clk);
    temp <= v;
    repeat (14) @(posedge clk);
    #1;
  endtask
  task automatic wrap_up;
    $display("comparisons %0d mismatches %0d", comparisons, n_mismatch);
    if (n_mismatch == 0 && comparisons > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  initial begin
    repeat (20000) @(posedge clk);
    n_mismatch++;
    wrap_up;
  end

  initial begin
    reset = 1'b1; req = '0; temp = 13'h0; stall = 1'b0; lf = 16'h0038;
    n_mismatch = 0; comparisons = 0;
    repeat (20) @(posedge clk);
    reset <= 1'b0;
    #1 `CHK(aoe, 1'b0)
    `CHK(aout, 1'b0)
    rd(`TSRB_A_CAP, `TSRB_CAP_RESET);
    rd(`TSRB_A_CFG, `TSRB_CFG_RESET);
    rd(`TSRB_A_MAKER, `TSRB_MAKER_ID);
    rd(`TSRB_A_PART, `TSRB_PART_ID);
    wr(`TSRB_A_CAP, 16'hffff);
    rd(`TSRB_A_CAP, 16'h007f);
    wr(`TSRB_A_CFG, 16'hf800);
    rd(`TSRB_A_CFG, 16'h0000);
    wr(`TSRB_A_HIGH, 16'hffff);
    rd(`TSRB_A_HIGH, 16'h1ffc);
    wr(`TSRB_A_HIGH, 16'h0320);
    wr(`TSRB_A_LOW, 16'h0190);
    wr(`TSRB_A_CRIT, 16'h07d0);
    rd(`TSRB_A_LOW, 16'h0190);
    wr(`TSRB_A_CFG, 16'h0008);
    for (int i = 0; i < 8; i++) begin
      lf = lfsr(lf);
      t = (i == 0) ? 13'h0320 : (i == 1) ? 13'h0190 : (i == 2) ? 13'h07d0 : lf[12:0];
      settemp(t);
      x = trips(t);
      `CHK(aoe, x[1] | x[0])
      rd(`TSRB_A_TEMP, {x, t});
      rd(`TSRB_A_CFG, {11'h0, x[1] | x[0], 4'h8});
    end
    settemp(13'h0200);
    wr(`TSRB_A_CFG, 16'h000a);
    `CHK(aoe, 1'b1)
    wr(`TSRB_A_CFG, 16'h0002);
    `CHK(aoe, 1'b1)
    wr(`TSRB_A_CFG, 16'h0000);
    `CHK(aoe, 1'b0)
    wr(`TSRB_A_CFG, 16'h0208);
    settemp(13'h0400);
    settemp(13'h0310);
    `CHK(aoe, 1'b1)
    settemp(13'h0300);
    `CHK(aoe, 1'b0)
    wr(`TSRB_A_CFG, 16'h0608);
    settemp(13'h0400);
    wr(`TSRB_A_CFG, 16'h0628);
    `CHK(aoe, 1'b1)
    settemp(13'h02d0);
    `CHK(aoe, 1'b1)
    settemp(13'h02b0);
    `CHK(aoe, 1'b0)
    wr(`TSRB_A_CFG, 16'h0408);
    settemp(13'h0100);
    settemp(13'h01b0);
    `CHK(aoe, 1'b1)
    settemp(13'h01d0);
    `CHK(aoe, 1'b0)
    settemp(13'h0200);
    wr(`TSRB_A_CFG, 16'h0009);
    wr(`TSRB_A_CFG, 16'h0029);
    `CHK(aoe, 1'b0)
    settemp(13'h0400);
    `CHK(aoe, 1'b1)
    settemp(13'h0200);
    `CHK(aoe, 1'b1)
    wr(`TSRB_A_CFG, 16'h0029);
    `CHK(aoe, 1'b0)
    rd(`TSRB_A_CFG, 16'h0009);
    settemp(13'h07e0);
    wr(`TSRB_A_CFG, 16'h0029);
    `CHK(aoe, 1'b1)
    settemp(13'h0200);
    wr(`TSRB_A_CFG, 16'h002d);
    settemp(13'h0400);
    `CHK(aoe, 1'b0)
    wr(`TSRB_A_CFG, 16'h0029);
    settemp(13'h0200);
    wr(`TSRB_A_CFG, 16'h0109);
    `CHK(cen, 1'b0)
    `CHK(aoe, 1'b1)
    settemp(13'h0500);
    rd(`TSRB_A_TEMP, {trips(13'h0200), 13'h0200});
    wr(`TSRB_A_CFG, 16'h0129);
    `CHK(aoe, 1'b0)
    settemp(13'h0200);
    wr(`TSRB_A_CFG, 16'h0000);
    `CHK(cen, 1'b1)
    wr(`TSRB_A_CFG, 16'h0048);
    wr(`TSRB_A_HIGH, 16'h0100);
    rd(`TSRB_A_HIGH, 16'h0320);
    wr(`TSRB_A_CFG, 16'h0145);
    `CHK(cen, 1'b1)
    rd(`TSRB_A_CFG, 16'h0048);
    wr(`TSRB_A_CFG, 16'h00c8);
    wr(`TSRB_A_CRIT, 16'h0100);
    rd(`TSRB_A_CRIT, 16'h07d0);
    @(posedge clk);
    reset <= 1'b1;
    repeat (3) @(posedge clk);
    reset <= 1'b0;
    rd(`TSRB_A_CFG, 16'h0000);
    @(posedge clk);
    stall <= 1'b1;
    n = 0;
    while (rel !== 1'b1 && n < 40) begin
      @(posedge clk);
      #1 n++;
    end
    `CHK(n, 20)
    @(posedge clk);
    stall <= 1'b0;
    #1 `CHK(rel, 1'b0)
    `CHK(aout, 1'b0)
    wrap_up;
  end
endmodule

// >>> tb/tsrb_conv_model.sv
// converter model feeding periodic samples to the register bank
`timescale 1ns/1ns
module tsrb_conv_model
  import tsrb_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        reset,
  input  wire logic        conv_enable,
  input  wire logic [12:0] temp_in,
  output tsrb_sample_t     sample
);
  logic [2:0] cnt_q;
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      cnt_q  <= 3'h0;
      sample <= '0;
    end else begin
      cnt_q        <= conv_enable ? cnt_q + 3'h1 : 3'h0;
      sample.valid <= conv_enable && cnt_q == 3'h7;
      // off-pulse data toggles so a stale value never passes for a sample
      sample.temp  <= (conv_enable && cnt_q == 3'h7) ? temp_in : ~sample.temp;
    end
  end
endmodule
